// ### lcd_pkg.sv
// Shared constants and types for the segment display timing block.
package lcd_pkg;
  // ==========================================================
  // Register map: one aligned word per register.
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_PHASE    = 8'h04;
  localparam logic [7:0] OFF_LADDER   = 8'h08;
  localparam logic [7:0] OFF_REFCTL   = 8'h0c;
  localparam logic [7:0] OFF_SEGEN0   = 8'h10;
  localparam logic [7:0] OFF_PIXEL0   = 8'h28;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h88;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h8c;
  localparam int unsigned SEG_REGS    = 6;
  localparam int unsigned PIX_REGS    = 24;
  localparam int unsigned SEG_CNT     = 48;
  // ==========================================================
  // Field positions and write masks.
  localparam int unsigned CTL_ON_BIT    = 7;
  localparam int unsigned CTL_HALT_BIT  = 6;
  localparam int unsigned CTL_PIXEL_WRITE_ERROR_BIT  = 5;
  localparam int unsigned CTL_SRC_LSB   = 2;
  localparam int unsigned CTL_MUX_LSB   = 0;
  localparam int unsigned PS_WAVE_BIT   = 7;
  localparam int unsigned PS_BIAS_BIT   = 6;
  localparam int unsigned PS_ACT_BIT    = 5;
  localparam int unsigned PS_PERMIT_BIT = 4;
  localparam int unsigned PS_PRE_LSB    = 0;
  localparam logic [7:0] CTL_WR_MASK    = 8'hcf;
  localparam logic [7:0] PS_WR_MASK     = 8'hcf;
  localparam logic [7:0] LADDER_MASK    = 8'hf7;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // Interrupt status bits.
  localparam int unsigned IRQ_PIXEL_WRITE_ERROR  = 0;
  localparam int unsigned IRQ_FRAME = 1;
  localparam int unsigned IRQ_W     = 2;
  // ==========================================================
  // Clock source codes and dividers.
  localparam logic [1:0]  SRC_INSTR = 2'h0;
  localparam logic [1:0]  SRC_SECONDARY_OSC  = 2'h1;
  localparam logic [12:0] SLOW_DIV  = 13'h0020;
  localparam int unsigned INSTR_DIV_DEF = 8192;
  localparam logic [1:0]  MUX_STATIC = 2'h0;
  localparam logic [1:0]  MUX_FOUR   = 2'h3;
  // ==========================================================
  // Driver state, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } drv_state_t;
  // Common-side drive bundle.
  typedef struct packed {
    logic [3:0] com_on;
    logic       phase;
    logic       bias_half;
    logic       static_mode;
  } drive_t;
  // Bus request bundle.
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_t;
endpackage

// ### lcd_tick_div.sv
// Clock source selection, fixed divider and programmable prescaler.
`timescale 1ns/10ps
module lcd_tick_div
  import lcd_pkg::*;
#(
  parameter int unsigned INSTR_DIV = INSTR_DIV_DEF
) (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [1:0] src_sel_i,
  input  wire logic       instr_tick_i,
  input  wire logic       secondary_osc_edge_i,
  input  wire logic       rc_edge_i,
  input  wire logic [3:0] prescale_i,
  output logic            tick_o
);
  logic        src_edge;    // Edge of the chosen source.
  logic [12:0] div_lim;     // Last count of the fixed divider.
  logic [12:0] div_r;       // Fixed divider count.
  logic        base_r;      // One pulse per divided source period.
  logic [3:0]  pre_r;       // Prescaler count.

  // ==========================================================
  // Source select
  // source and divider choice
  always_comb begin
    if (src_sel_i == SRC_INSTR) begin
      src_edge = instr_tick_i;
      div_lim  = 13'(INSTR_DIV - 1);
    end else if (src_sel_i == SRC_SECONDARY_OSC) begin
      src_edge = secondary_osc_edge_i;
      div_lim  = SLOW_DIV - 13'h0001;
    end else begin
      src_edge = rc_edge_i;
      div_lim  = SLOW_DIV - 13'h0001;
    end
  end

  // Fixed divider; held clear while the driver is stopped.
  // counters held when off
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r  <= 13'h0000;
      base_r <= 1'b0;
    end else if (!run_i) begin
      div_r  <= 13'h0000;
      base_r <= 1'b0;
    end else begin
      base_r <= src_edge && (div_r >= div_lim);
      if (src_edge) begin
        div_r <= (div_r >= div_lim) ? 13'h0000 : div_r + 13'h0001;
      end
    end
  end

  // Prescaler: one output pulse every field-plus-one base pulses.
  // divide by field plus one
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_r  <= 4'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      pre_r  <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= base_r && (pre_r >= prescale_i);
      if (base_r) begin
        pre_r <= (pre_r >= prescale_i) ? 4'h0 : pre_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_src_divide: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    run_i && src_edge && div_r == div_lim |=> base_r || !run_i)
    else $error("divider missed its last count");
  chk_pre_tick: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    run_i && base_r && pre_r != prescale_i && $stable(prescale_i) |=> !tick_o)
    else $error("prescaler ticked early");
endmodule

// ### lcd_panel_ctrl.sv
// Segment display control and phase timing core with an APB slave.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
// Behaviour
// - drive common and segment timing for panels
// - four commons, up to 48 segments
// - thirty-six registers in the set
// - control bit 7 runs or stops driver
// - control bit 6 halts driver in sleep
// - blocked pixel write sets error flag
// - two-bit field picks clock source
// - two-bit field picks number of commons
// - phase bit 7 picks waveform kind
// - bias select halves bias for two/three
// - phase bit 5 shows driver active
// - phase bit 4 shows pixel write permit
// - prescaler divides by field plus one
// - pixel bit one means dark segment
// - segment enable turns pin into driver
module lcd_panel_ctrl
  import lcd_pkg::*;
#(
  parameter int unsigned INSTR_DIV = INSTR_DIV_DEF
) (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              instr_tick_i,
  input  wire logic              secondary_osc_i,
  input  wire logic              internal_rc_osc_i,
  input  wire logic              sleep_i,
  output drive_t                 drive_o,
  output logic [SEG_CNT-1:0]     seg_dark_o,
  output logic [SEG_CNT-1:0]     seg_enable_o,
  output logic                   driver_active_o,
  output logic                   irq_o
);
  // ==========================================================
  // Declarations
  apb_req_t          req;          // Bus request bundle.
  logic [7:0]        ctl_r;        // Display control register.
  logic [7:0]        ps_r;         // Writable phase fields.
  logic [7:0]        ladder_r;     // Reference ladder register.
  logic [7:0]        refctl_r;     // Reference control register.
  logic [SEG_REGS-1:0][7:0] segen_r;  // Segment enables.
  logic [PIX_REGS-1:0][7:0] pixel_r;  // Pixel data.
  logic [IRQ_W-1:0]  stat_r;       // Sticky event bits.
  logic [IRQ_W-1:0]  mask_r;       // Event enables.
  logic [5:0]        idx;          // Word index of the access.
  logic              acc;          // Access phase of a transfer.
  logic              wr;           // Write taking effect now.
  logic              mapped;       // Address hits a register.
  logic              pix_hit;      // Address hits pixel data.
  logic [4:0]        pix_idx;      // Pixel word index.
  logic              blocked;      // Pixel write refused.
  logic              permit;       // Pixel writes allowed.
  logic [7:0]        ps_view;      // Phase register as read.
  logic [31:0]       rd_nxt;       // Read data next value.
  logic [2:0][1:0]   pin_s;        // Pin synchronisers, per stage.
  logic [1:0]        pin_lvl_r;    // Agreed pin levels.
  logic [1:0]        pin_edge;     // Rising edge of agreed level.
  drv_state_t        state_r;      // Driver state.
  drv_state_t        state_nxt;
  logic              run;          // Driver is running.
  logic              tick;         // Timing step from the divider.
  logic [1:0]        com_r;        // Current common.
  logic              phase_r;      // Current drive phase.
  logic              frame_end;    // Last step of a frame.
  logic              frame_open_r; // Slot after a frame boundary.
  logic [1:0]        mux;          // Commons select.
  logic              pix00;        // Pixel for segment 0, common 0.

  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};
  assign mux = ctl_r[CTL_MUX_LSB +: 2];
  assign pix00 = pixel_r[0][0];

  // ==========================================================
  // Pin synchronisers
  // Three stages; only the second and third stage are compared, so the
  // first stage never feeds logic and a level counts once it is stable.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s     <= '0;
      pin_lvl_r <= 2'h0;
    end else begin
      pin_s[0] <= {internal_rc_osc_i, secondary_osc_i};
      pin_s[1] <= pin_s[0];
      pin_s[2] <= pin_s[1];
      for (int i = 0; i < 2; i++) begin
        if (pin_s[1][i] == pin_s[2][i]) begin
          pin_lvl_r[i] <= pin_s[2][i];
        end
      end
    end
  end

  // A rising edge is an agreed high seen while the held level is low.
  assign pin_edge = pin_s[1] & pin_s[2] & ~pin_lvl_r;

  // ==========================================================
  // Bus decode
  // Zero-wait slave: the access phase always completes at once.
  assign idx     = req.addr[7:2];
  assign acc     = req.sel && req.enable;
  assign pready  = acc;
  assign wr      = acc && req.write && mapped;
  assign pix_hit = (req.addr >= OFF_PIXEL0) && (req.addr < OFF_IRQ_STAT);
  assign pix_idx = 5'(idx - OFF_PIXEL0[7:2]);

  always_comb begin
    mapped = (req.addr[1:0] == 2'h0) && (req.addr <= OFF_IRQ_MASK);
    pslverr = acc && !mapped;
  end

  // permit while idle or at a frame boundary
  assign permit  = !run || frame_open_r;
  assign blocked = wr && pix_hit && !permit;

  // Phase register view with the two live status bits folded in.
  // active bit tracks the running state
  always_comb begin
    ps_view = ps_r & PS_WR_MASK;
    ps_view[PS_ACT_BIT]    = run;
    ps_view[PS_PERMIT_BIT] = permit;
  end

  // ==========================================================
  // Read data
  // Data is captured in the setup cycle so that it stands in a flop
  // through the access phase; reserved bits read as zero.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (pix_hit) begin
      rd_nxt[7:0] = pixel_r[pix_idx];
    end else if (req.addr >= OFF_SEGEN0 && req.addr < OFF_PIXEL0) begin
      rd_nxt[7:0] = segen_r[3'(idx - OFF_SEGEN0[7:2])];
    end else begin
      case (req.addr)
        OFF_CONTROL:  rd_nxt[7:0] = ctl_r;
        OFF_PHASE:    rd_nxt[7:0] = ps_view;
        OFF_LADDER:   rd_nxt[7:0] = ladder_r;
        OFF_REFCTL:   rd_nxt[7:0] = refctl_r;
        OFF_IRQ_STAT: rd_nxt[IRQ_W-1:0] = stat_r;
        OFF_IRQ_MASK: rd_nxt[IRQ_W-1:0] = mask_r;
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata <= 32'h0000_0000;
    end else if (req.sel && !req.enable && !req.write) begin
      prdata <= rd_nxt;
    end
  end

  // ==========================================================
  // Control register
  // The error flag clears only when software writes it as zero; a new
  // refused pixel write in the same cycle wins over that clear.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_r <= REG_RESET;
    end else begin
      if (wr && req.addr == OFF_CONTROL) begin
        // enable and sleep bits are plain fields
        ctl_r <= (req.wdata[7:0] & CTL_WR_MASK)
               | (ctl_r & 8'h20 & req.wdata[7:0]);
      end
      if (blocked) begin
        ctl_r[CTL_PIXEL_WRITE_ERROR_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  // The bias select is stored as written; software keeps it clear in
  // static and four-common modes, and the drive ignores it there.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ps_r     <= REG_RESET;
      ladder_r <= REG_RESET;
      refctl_r <= REG_RESET;
      mask_r   <= '0;
    end else if (wr) begin
      case (req.addr)
        OFF_PHASE:    ps_r     <= req.wdata[7:0] & PS_WR_MASK;
        OFF_LADDER:   ladder_r <= req.wdata[7:0] & LADDER_MASK;
        OFF_REFCTL:   refctl_r <= req.wdata[7:0];
        OFF_IRQ_MASK: mask_r   <= req.wdata[IRQ_W-1:0];
        default:      mask_r   <= mask_r;
      endcase
    end
  end

  // ==========================================================
  // Segment enables and pixel data, one entry per word.
  genvar g;
  generate
    for (g = 0; g < SEG_REGS; g++) begin : g_segen
      // enable bit hands the pin over
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          segen_r[g] <= REG_RESET;
        end else if (wr && req.addr == OFF_SEGEN0 + 8'(4 * g)) begin
          segen_r[g] <= req.wdata[7:0];
        end
      end
    end
    for (g = 0; g < PIX_REGS; g++) begin : g_pixel
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pixel_r[g] <= REG_RESET;
        end else if (wr && pix_hit && permit && pix_idx == 5'(g)) begin
          pixel_r[g] <= req.wdata[7:0];
        end
      end
    end
  endgenerate

  assign seg_enable_o = segen_r;

  // ==========================================================
  // Driver state
  // Sleep only stops the driver when the halt-in-sleep bit is set.
  // sleep halts only when asked
  always_comb begin
    case (state_r)
      ST_IDLE, ST_RUN, ST_HALT: begin
        if (!ctl_r[CTL_ON_BIT]) begin
          state_nxt = ST_IDLE;
        end else if (sleep_i && ctl_r[CTL_HALT_BIT]) begin
          state_nxt = ST_HALT;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign run = (state_r == ST_RUN);
  assign driver_active_o = run;

  // ==========================================================
  // Timing step source
  lcd_tick_div #(
    .INSTR_DIV (INSTR_DIV)
  ) u_div (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .run_i        (run),
    .src_sel_i    (ctl_r[CTL_SRC_LSB +: 2]),
    .instr_tick_i (instr_tick_i),
    .secondary_osc_edge_i  (pin_edge[0]),
    .rc_edge_i    (pin_edge[1]),
    .prescale_i   (ps_r[PS_PRE_LSB +: 4]),
    .tick_o       (tick)
  );

  // ==========================================================
  // Common and phase sequencer
  // Type-A flips phase inside each common slot; Type-B walks all
  // commons then flips phase at the frame boundary.
  // waveform kind picks phase cadence
  always_comb begin
    if (ps_r[PS_WAVE_BIT]) begin
      frame_end = tick && (com_r >= mux);
    end else begin
      frame_end = tick && (com_r >= mux) && phase_r;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      com_r   <= 2'h0;
      phase_r <= 1'b0;
    end else if (!run) begin
      com_r   <= 2'h0;
      phase_r <= 1'b0;
    end else if (tick) begin
      if (ps_r[PS_WAVE_BIT]) begin
        // wrap after the last selected common
        com_r <= (com_r >= mux) ? 2'h0 : com_r + 2'h1;
        if (com_r >= mux) begin
          phase_r <= !phase_r;
        end
      end else begin
        phase_r <= !phase_r;
        if (phase_r) begin
          com_r <= (com_r >= mux) ? 2'h0 : com_r + 2'h1;
        end
      end
    end
  end

  // Pixel writes are opened for one step after each frame boundary so
  // that a frame never shows half old and half new data.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_open_r <= 1'b0;
    end else if (!run || tick) begin
      frame_open_r <= run && frame_end;
    end
  end

  // ==========================================================
  // Panel drive outputs
  // common drive follows the sequencer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_o <= '0;
    end else begin
      drive_o.com_on      <= run ? (4'h1 << com_r) : 4'h0;
      drive_o.phase       <= phase_r;
      // half bias only for two or three commons
      drive_o.bias_half   <= ps_r[PS_BIAS_BIT] && mux != MUX_STATIC
                             && mux != MUX_FOUR;
      drive_o.static_mode <= (mux == MUX_STATIC);
    end
  end

  // Pixel word for segment s on common c is c * 6 + s / 8.
  generate
    for (g = 0; g < SEG_CNT; g++) begin : g_seg
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          seg_dark_o[g] <= 1'b0;
        end else begin
          seg_dark_o[g] <= run && segen_r[g / 8][g % 8]
                           && pixel_r[5'(com_r) * 5'd6 + 5'(g / 8)][g % 8];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interrupts
  // A read of the status word clears only the bits that it returned, so an
  // event that lands after the word was captured, or in the clearing cycle,
  // survives the clear instead of being lost unseen.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_r <= '0;
    end else begin
      stat_r <= (acc && !req.write && req.addr == OFF_IRQ_STAT ? stat_r & ~prdata[IRQ_W-1:0] : stat_r)
              | {run && frame_end, blocked};
    end
  end

  assign irq_o = |(stat_r & mask_r);

  // ==========================================================
  // Checks
  chk_pixel_write_error_raise: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    blocked |=> ctl_r[CTL_PIXEL_WRITE_ERROR_BIT] && stat_r[IRQ_PIXEL_WRITE_ERROR])
    else $error("refused pixel write did not flag");
  chk_pixel_keep: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    blocked |=> $stable(pixel_r))
    else $error("refused pixel write changed data");
  chk_idle_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !run |=> com_r == 2'h0 && !phase_r && drive_o.com_on == 4'h0)
    else $error("counters moved while stopped");
  chk_active_on: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (ctl_r[CTL_ON_BIT] && !sleep_i) [*2] |-> driver_active_o)
    else $error("enabled driver not active");
  chk_sleep_halt: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    sleep_i && ctl_r[CTL_HALT_BIT] |=> !driver_active_o)
    else $error("driver ran during sleep halt");
  chk_com_range: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    tick && run && $stable(mux) |=> com_r <= mux)
    else $error("common index beyond selection");
  chk_seg_pixel: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    run && com_r == 2'h0 && segen_r[0][0] |=> seg_dark_o[0] == $past(pix00))
    else $error("segment drive does not match pixel");
  chk_bias_mode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    mux == MUX_FOUR || mux == MUX_STATIC |=> !drive_o.bias_half)
    else $error("half bias in static or four-common mode");
  chk_frame_irq: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    run && frame_end |=> stat_r[IRQ_FRAME] ##0 frame_open_r)
    else $error("frame boundary not recorded");
endmodule

// ### lcd_panel_model.sv
// Behavioural display panel that measures the drive timing it receives.
`timescale 1ns/10ps
module lcd_panel_model
  import lcd_pkg::*;
(
  input  wire logic   clock_i,
  input  wire logic   clr_i,
  input  wire drive_t drive_i,
  output int          gap_o,
  output logic [3:0]  com_seen_o
);
  // ==========================================================
  // Step timing seen on the common side.
  drive_t prev_r; // Drive bundle at the previous edge.
  int     cnt_r;  // Cycles since the drive last changed.
  // record steps and commons
  // Every waveform step changes phase or common, so any change marks one step.
  always_ff @(posedge clock_i) begin
    prev_r     <= drive_i;
    cnt_r      <= (drive_i != prev_r) ? 1 : cnt_r + 1;
    gap_o      <= (drive_i != prev_r) ? cnt_r : gap_o;
    com_seen_o <= clr_i ? 4'h0 : (com_seen_o | drive_i.com_on);
  end
endmodule

// ### lcd_panel_ctrl_bench.sv
// Self-checking bench for the segment display control core.
`timescale 1ns/10ps
module lcd_panel_ctrl_bench;
  import lcd_pkg::*;
  // ==========================================================
  // Stimulus and observation signals.
  localparam int unsigned DIV = 16; // Shortened instruction divider keeps the run brief.
  logic               clock_i    = 1'b0;
  logic               rst_b_i    = 1'b0;
  logic               psel       = 1'b0;
  logic               penable    = 1'b0;
  logic               pwrite     = 1'b0;
  logic               sleep_i    = 1'b0;
  logic               clr        = 1'b1;
  logic [7:0]         paddr      = 8'h00;
  logic [31:0]        pwdata     = 32'h0;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, err, driver_active_o, irq_o, wave, bias;
  logic [2:0]         ph         = 3'h0; // Free-running pattern feeding the three sources.
  logic [3:0]         p, seen;
  drive_t             drive_o;
  logic [SEG_CNT-1:0] seg_dark_o, seg_enable_o;
  int                 gap, ex, n_mismatch = 0, cmp_count = 0;
  logic [63:0]        notes[$]; // Read notes: mask in the upper half, value below.
  logic [63:0]        note;     // Oldest note, taken off before it is compared.
  always #2.5 clock_i = ~clock_i;
  // Instruction pulse every 2 cycles, secondary edge every 4, internal edge every 8.
  always @(posedge clock_i) ph <= ph + 3'h1;
  lcd_panel_ctrl #(.INSTR_DIV(DIV)) lcd_panel_ctrl_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_tick_i(ph[0]),
    .secondary_osc_i(ph[1]), .internal_rc_osc_i(ph[2]), .sleep_i(sleep_i), .drive_o(drive_o),
    .seg_dark_o(seg_dark_o), .seg_enable_o(seg_enable_o), .driver_active_o(driver_active_o),
    .irq_o(irq_o));
  lcd_panel_model lcd_panel_model_i (.clock_i(clock_i), .clr_i(clr), .drive_i(drive_o),
    .gap_o(gap), .com_seen_o(seen));
  // ==========================================================
  // Comparison, bus cycle and closing tasks.
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    cmp_count++;
    if (seen_v !== exp_v) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  // One zero-wait transfer; a read leaves its note for the monitor.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) notes.push_back({m, d});
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Monitor: every completed read is matched against the oldest note.
  always @(posedge clock_i) begin
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else begin
        note = notes.pop_front();
        check(prdata & note[63:32], note[31:0] & note[63:32]);
      end
    end
  end
  // Watchdog: far beyond the at most roughly 22k cycles the sequence needs.
  initial begin
    #400us;
    n_mismatch++;
    finish_test();
  end
  // ==========================================================
  // Main sequence.
  initial begin
    ex = $urandom(32'hd043);
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    // Reset values; the permit bit reads 1 while idle, so it is masked.
    for (int i = 0; i < 4; i++) apb(1'b0, 8'(4 * i), 32'h0, (i == 1) ? 32'hef : 32'hffffffff);
    apb(1'b1, OFF_LADDER, 32'hff, 32'h0);
    apb(1'b0, OFF_LADDER, 32'hf7, 32'hffffffff);
    apb(1'b1, OFF_CONTROL, 32'h6f, 32'h0);
    apb(1'b0, OFF_CONTROL, 32'h4f, 32'hffffffff);
    apb(1'b1, OFF_PHASE, 32'hff, 32'h0);
    apb(1'b0, OFF_PHASE, 32'hdf, 32'hffffffff);
    apb(1'b0, 8'h90, 32'h0, 32'hffffffff);
    check(err, 1'b1);
    apb(1'b1, OFF_SEGEN0, 32'h01, 32'h0);
    apb(1'b1, OFF_PIXEL0, 32'h01, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h01, 32'h0);
    // One pass per source code; the commons count follows the code.
    for (int s = 0; s < 4; s++) begin
      p = 4'($urandom % 4);
      wave = 1'($urandom);
      bias = (s == 1 || s == 2) ? 1'($urandom) : 1'b0; // Static and four commons keep bias 0.
      clr <= 1'b1;
      apb(1'b1, OFF_CONTROL, 32'h0, 32'h0);
      apb(1'b0, OFF_PHASE, 32'h0, 32'h20);
      check(driver_active_o, 1'b0);
      apb(1'b1, OFF_PHASE, {24'h0, wave, bias, 2'b00, p}, 32'h0);
      clr <= 1'b0;
      apb(1'b1, OFF_CONTROL, 32'h80 | (s << 2) | s, 32'h0);
      ex = (s == 0 ? 2 * DIV : (s == 1 ? 128 : 256)) * (p + 1);
      repeat (8 * ex) @(posedge clock_i);
      check(gap, ex);
      check(seen, (s == 0) ? 4'h1 : (s == 1) ? 4'h3 : (s == 2) ? 4'h7 : 4'hf);
      check(drive_o.static_mode, s == 0);
      check(drive_o.bias_half, bias);
      check(driver_active_o, 1'b1);
      if (s == 0) check({seg_dark_o[0], seg_enable_o[0]}, 2'b11);
    end
    sleep_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    check(driver_active_o, 1'b1);
    apb(1'b1, OFF_CONTROL, 32'hcf, 32'h0);
    // The state flop takes the new control word one edge later.
    @(posedge clock_i);
    check(driver_active_o, 1'b0);
    sleep_i <= 1'b0;
    apb(1'b1, OFF_CONTROL, 32'h8f, 32'h0);
    check(driver_active_o, 1'b1);
    // Catch a moment with pixel writes barred, then attempt one.
    rd = 32'hff;
    for (int k = 0; k < 300 && rd[PS_PERMIT_BIT] !== 1'b0; k++) apb(1'b0, OFF_PHASE, 32'h0, 32'h0);
    apb(1'b1, OFF_PIXEL0, 32'h00, 32'h0);
    apb(1'b0, OFF_PIXEL0, 32'h01, 32'hff);
    apb(1'b0, OFF_CONTROL, 32'haf, 32'hff);
    check(irq_o, 1'b1);
    apb(1'b0, OFF_IRQ_STAT, 32'h01, 32'h01);
    apb(1'b0, OFF_IRQ_STAT, 32'h00, 32'h01);
    check(irq_o, 1'b0);
    apb(1'b1, OFF_CONTROL, 32'h8f, 32'h0);
    apb(1'b0, OFF_CONTROL, 32'h8f, 32'hff);
    // A reset in mid-run must stop the drive and clear the control word.
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    check(drive_o.com_on, 4'h0);
    check(driver_active_o, 1'b0);
    apb(1'b0, OFF_CONTROL, 32'h0, 32'hff);
    finish_test();
  end
endmodule
